//--- pkg/record_pack_pkg.sv
`default_nettype none

package record_pack_pkg;

    // =========================================================
    // Record layout
    // =========================================================
    localparam logic [8:0] BASE_UNIT_BYTES    = 9'h018;
    localparam logic [8:0] MAX_RECORD_BYTES   = 9'h110;
    localparam logic [7:0] PAYLOAD_UNIT_BYTES = 8'h08;
    localparam logic [7:0] CLASSIC_MAX_LEN    = 8'h08;
    localparam logic [7:0] FLEXRAY_MAX_LEN    = 8'hfe;
    localparam logic [4:0] MAX_EXT_UNITS      = 5'h1f;
    localparam int         OFS_TYPE           = 12;
    localparam int         OFS_FLAGS          = 13;
    localparam int         OFS_INFO           = 14;
    localparam int         OFS_LEN            = 15;
    localparam int         OFS_BASE_PAYLOAD   = 16;

    // Flags byte bit positions and the extended bit of the identifier
    localparam int FLG_STARTUP    = 0;
    localparam int FLG_SYNC       = 1;
    localparam int FLG_PREAMBLE   = 2;
    localparam int FLG_CHAN_A     = 4;
    localparam int FLG_CHAN_B     = 5;
    localparam int FLG_EVENT_SLOT = 0;
    localparam int FLG_ECHO       = 7;
    localparam int ID_EXT_BIT     = 29;

    // Protocol nibble of the type byte
    localparam logic [3:0] TYPE_PROT_CAN     = 4'h0;
    localparam logic [3:0] TYPE_PROT_FLEXRAY = 4'h2;
    localparam logic [3:0] TYPE_PROT_LIN     = 4'h4;

    typedef enum logic [1:0] {
        PROT_CAN     = 2'h0,
        PROT_CANFD   = 2'h1,
        PROT_FLEXRAY = 2'h2,
        PROT_LIN     = 2'h3
    } prot_e;

    typedef enum logic [1:0] {
        KIND_TS   = 2'h0,
        KIND_HDR  = 2'h1,
        KIND_BASE = 2'h2,
        KIND_EXT  = 2'h3
    } kind_e;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_HDR   = 3'h1,
        ST_BASE  = 3'h3,
        ST_EXT   = 3'h2,
        ST_DRAIN = 3'h6
    } st_e;

    // =========================================================
    // Register map
    // =========================================================
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_STATUS    = 12'h004;
    localparam logic [11:0] REG_LAST_SIZE = 12'h008;
    localparam logic [11:0] REG_REC_CNT   = 12'h00c;
    localparam logic [11:0] REG_DROP_CNT  = 12'h010;
    localparam int          CTRL_ENABLE   = 0;
    localparam int          CTRL_PAD_ZERO = 1;
    localparam logic [7:0]  CTRL_MASK     = 8'h03;
    localparam logic [7:0]  CTRL_RESET    = 8'h03;

endpackage : record_pack_pkg

`default_nettype wire

//--- src/raw_frame_record_packer.sv
// Our own choices: the placing of the registers and the APB register port.
`default_nettype none

module raw_frame_record_packer
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic [11:0]            paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   hdr_valid,
    output logic                        hdr_ready,
    input  wire record_pack_pkg::prot_e hdr_prot,
    input  wire logic [3:0]             hdr_subtype,
    input  wire logic [63:0]            hdr_timestamp,
    input  wire logic [28:0]            hdr_id,
    input  wire logic                   hdr_extended,
    input  wire logic                   hdr_echo,
    input  wire logic                   hdr_startup,
    input  wire logic                   hdr_sync,
    input  wire logic                   hdr_preamble,
    input  wire logic                   hdr_chan_a,
    input  wire logic                   hdr_chan_b,
    input  wire logic                   hdr_event_slot,
    input  wire logic [5:0]             hdr_event_id,
    input  wire logic [5:0]             hdr_cycle,
    input  wire logic [7:0]             hdr_valid_byte_count,
    input  wire logic [63:0]            hdr_payload,
    input  wire logic                   pl_valid,
    output logic                        pl_ready,
    input  wire logic [63:0]            pl_data,
    output logic                        rec_valid,
    input  wire logic                   rec_ready,
    output logic      [63:0]            rec_data,
    output logic                        rec_last
);
    import record_pack_pkg::*;

    // =========================================================
    // State
    // =========================================================
    typedef struct packed {
        st_e         st;
        kind_e       kind;
        logic        ov;
        logic        olast;
        logic [63:0] odata;
        logic [7:0]  typ;
        logic [7:0]  flags;
        logic [7:0]  info;
        logic [7:0]  len;
        logic [31:0] ident;
        logic [63:0] base;
        logic [4:0]  ext_left;
        logic [7:0]  rem;
        logic [5:0]  words;
        logic [7:0]  ctrl;
        logic [31:0] rec_cnt;
        logic [31:0] drop_cnt;
        logic [8:0]  last_size;
        logic [31:0] prdata;
    } state_s;

    state_s      s_ff;
    state_s      nxt_s;
    logic        can_load;
    logic        accept;
    logic        apb_setup;
    logic        apb_access;
    logic [7:0]  new_flags;
    logic [7:0]  new_info;
    logic [31:0] new_ident;
    logic [3:0]  new_prot;

    // =========================================================
    // Functions
    // =========================================================
    function automatic logic len_ok(input prot_e p, input logic [7:0] n);
        logic ok;
        ok = 1'b0;
        unique case (p)
            PROT_CAN, PROT_LIN: ok = (n <= CLASSIC_MAX_LEN);
            PROT_CANFD: begin
                ok = (n <= CLASSIC_MAX_LEN) || (n == 8'h0c) || (n == 8'h10)
                  || (n == 8'h14) || (n == 8'h18) || (n == 8'h20)
                  || (n == 8'h30) || (n == 8'h40);
            end
            PROT_FLEXRAY: ok = (n <= FLEXRAY_MAX_LEN);
        endcase
        return ok;
    endfunction : len_ok

    function automatic logic [4:0] ext_units(input logic [7:0] n);
        logic [7:0] m;
        m = n - 8'h01;
        return (n <= PAYLOAD_UNIT_BYTES) ? 5'h00 : m[7:3];
    endfunction : ext_units

    function automatic logic [8:0] rec_size(input logic [7:0] n);
        logic [7:0] m;
        m = (n - 8'h01) & 8'hf8;
        return BASE_UNIT_BYTES + ((n > PAYLOAD_UNIT_BYTES) ? {1'b0, m} : 9'h000);
    endfunction : rec_size

    function automatic logic [63:0] keep_bytes(input logic [63:0] d, input logic [7:0] n,
                                               input logic pad);
        logic [63:0] m;
        m = '0;
        for (int i = 0; i < 8; i++) begin
            if (i < int'(n)) begin
                m[i*8 +: 8] = 8'hff;
            end
        end
        return pad ? (d & m) : d;
    endfunction : keep_bytes

    function automatic logic reg_hit(input logic [11:0] a);
        return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_LAST_SIZE)
            || (a == REG_REC_CNT) || (a == REG_DROP_CNT);
    endfunction : reg_hit

    // =========================================================
    // Field encoding of an incoming frame
    // =========================================================
    always_comb begin
        new_flags = 8'h00;
        new_info  = 8'h00;
        new_ident = 32'h0000_0000;
        new_prot  = TYPE_PROT_CAN;
        new_flags[FLG_ECHO] = hdr_echo;
        unique case (hdr_prot)
            PROT_CAN, PROT_CANFD: begin
                if (hdr_extended) begin
                    new_ident = {3'b000, hdr_id};
                    new_ident[ID_EXT_BIT] = 1'b1;
                end else begin
                    new_ident = {21'h000000, hdr_id[10:0]};
                end
            end
            PROT_FLEXRAY: begin
                new_prot                = TYPE_PROT_FLEXRAY;
                new_flags[FLG_STARTUP]  = hdr_startup;
                new_flags[FLG_SYNC]     = hdr_sync;
                new_flags[FLG_PREAMBLE] = hdr_preamble;
                new_flags[FLG_CHAN_A]   = hdr_chan_a;
                new_flags[FLG_CHAN_B]   = hdr_chan_b;
                new_info                = {2'b00, hdr_cycle};
                new_ident               = {16'h0000, hdr_id[15:0]};
            end
            PROT_LIN: begin
                new_prot                  = TYPE_PROT_LIN;
                new_flags[FLG_EVENT_SLOT] = hdr_event_slot;
                if (hdr_event_slot) begin
                    new_info  = {2'b00, hdr_event_id};
                    new_ident = {26'h0000000, hdr_payload[5:0]};
                end else begin
                    new_ident = {26'h0000000, hdr_id[5:0]};
                end
            end
        endcase
    end

    // =========================================================
    // Next state
    // =========================================================
    always_comb begin
        nxt_s      = s_ff;
        apb_setup  = psel && !penable;
        apb_access = psel && penable;
        can_load   = !s_ff.ov || rec_ready;
        hdr_ready  = s_ff.ctrl[CTRL_ENABLE] && (s_ff.st == ST_IDLE) && can_load;
        pl_ready   = ((s_ff.st == ST_EXT) && can_load) || (s_ff.st == ST_DRAIN);
        accept     = hdr_valid && hdr_ready;

        // Register writes come first so that a counted event wins over a clear
        if (apb_access && pwrite) begin
            unique case (paddr)
                REG_CTRL: begin
                    if (pstrb[0]) begin
                        nxt_s.ctrl = pwdata[7:0] & CTRL_MASK;
                    end
                end
                REG_REC_CNT:  nxt_s.rec_cnt  = 32'h0000_0000;
                REG_DROP_CNT: nxt_s.drop_cnt = 32'h0000_0000;
                default: ;
            endcase
        end
        if (apb_setup) begin
            unique case (paddr)
                REG_CTRL:      nxt_s.prdata = {24'h000000, s_ff.ctrl};
                REG_STATUS:    nxt_s.prdata = {19'h00000, s_ff.ext_left, 4'h0,
                                               s_ff.ov, s_ff.st};
                REG_LAST_SIZE: nxt_s.prdata = {23'h000000, s_ff.last_size};
                REG_REC_CNT:   nxt_s.prdata = s_ff.rec_cnt;
                REG_DROP_CNT:  nxt_s.prdata = s_ff.drop_cnt;
                default:       nxt_s.prdata = 32'h0000_0000;
            endcase
        end

        if (s_ff.ov && rec_ready) begin
            nxt_s.ov = 1'b0;
        end

        unique case (s_ff.st)
            ST_IDLE: begin
                if (accept) begin
                    nxt_s.ext_left = ext_units(hdr_valid_byte_count);
                    if (len_ok(hdr_prot, hdr_valid_byte_count)) begin
                        nxt_s.typ   = {new_prot, hdr_subtype};
                        nxt_s.flags = new_flags;
                        nxt_s.info  = new_info;
                        nxt_s.ident = new_ident;
                        nxt_s.len   = hdr_valid_byte_count;
                        nxt_s.base  = hdr_payload;
                        nxt_s.rem   = hdr_valid_byte_count - PAYLOAD_UNIT_BYTES;
                        nxt_s.ov    = 1'b1;
                        nxt_s.olast = 1'b0;
                        nxt_s.kind  = KIND_TS;
                        nxt_s.odata = hdr_timestamp;
                        nxt_s.words = 6'h01;
                        nxt_s.st    = ST_HDR;
                    end else begin
                        nxt_s.drop_cnt = nxt_s.drop_cnt + 32'h0000_0001;
                        if (ext_units(hdr_valid_byte_count) != 5'h00) begin
                            nxt_s.st = ST_DRAIN;
                        end
                    end
                end
            end
            ST_HDR: begin
                if (can_load) begin
                    // Bytes 8..15: identifier, type, flags, info, length
                    nxt_s.ov    = 1'b1;
                    nxt_s.kind  = KIND_HDR;
                    nxt_s.odata = {s_ff.len, s_ff.info, s_ff.flags,
                                   s_ff.typ, s_ff.ident};
                    nxt_s.words = s_ff.words + 6'h01;
                    nxt_s.st    = ST_BASE;
                end
            end
            ST_BASE: begin
                if (can_load) begin
                    nxt_s.ov    = 1'b1;
                    nxt_s.kind  = KIND_BASE;
                    nxt_s.odata = keep_bytes(s_ff.base, s_ff.len,
                                             s_ff.ctrl[CTRL_PAD_ZERO]);
                    nxt_s.words = s_ff.words + 6'h01;
                    nxt_s.olast = (s_ff.ext_left == 5'h00);
                    nxt_s.st    = (s_ff.ext_left == 5'h00) ? ST_IDLE : ST_EXT;
                    if (s_ff.ext_left == 5'h00) begin
                        nxt_s.rec_cnt   = nxt_s.rec_cnt + 32'h0000_0001;
                        nxt_s.last_size = rec_size(s_ff.len);
                    end
                end
            end
            ST_EXT: begin
                if (can_load && pl_valid) begin
                    nxt_s.ov       = 1'b1;
                    nxt_s.kind     = KIND_EXT;
                    nxt_s.odata    = keep_bytes(pl_data, s_ff.rem,
                                                s_ff.ctrl[CTRL_PAD_ZERO]);
                    nxt_s.rem      = (s_ff.rem > PAYLOAD_UNIT_BYTES) ?
                                     s_ff.rem - PAYLOAD_UNIT_BYTES : 8'h00;
                    nxt_s.words    = s_ff.words + 6'h01;
                    nxt_s.ext_left = s_ff.ext_left - 5'h01;
                    nxt_s.olast    = (s_ff.ext_left == 5'h01);
                    if (s_ff.ext_left == 5'h01) begin
                        nxt_s.st        = ST_IDLE;
                        nxt_s.rec_cnt   = nxt_s.rec_cnt + 32'h0000_0001;
                        nxt_s.last_size = rec_size(s_ff.len);
                    end
                end
            end
            ST_DRAIN: begin
                // Payload units of a refused frame are swallowed
                if (pl_valid) begin
                    nxt_s.ext_left = s_ff.ext_left - 5'h01;
                    if (s_ff.ext_left == 5'h01) begin
                        nxt_s.st = ST_IDLE;
                    end
                end
            end
            default: nxt_s.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_ff      <= '0;
            s_ff.ctrl <= CTRL_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    assign prdata    = s_ff.prdata;
    assign pready    = 1'b1;
    assign pslverr   = apb_access && !reg_hit(paddr);
    assign rec_valid = s_ff.ov;
    assign rec_data  = s_ff.odata;
    assign rec_last  = s_ff.olast;

    // =========================================================
    // Assertions
    // =========================================================
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_flag_echo:
        assert property (accept && len_ok(hdr_prot, hdr_valid_byte_count)
                         |=> s_ff.flags[FLG_ECHO] == $past(hdr_echo))
        else $error("echo flag does not follow the frame");
    a_header_word:
        assert property (rec_valid && s_ff.kind == KIND_HDR
                         |-> rec_data[63:32] == {s_ff.len, s_ff.info, s_ff.flags, s_ff.typ})
        else $error("header word layout wrong");
    a_flexray_flags:
        assert property (accept && hdr_prot == PROT_FLEXRAY
                         && len_ok(hdr_prot, hdr_valid_byte_count)
                         |=> s_ff.flags[6:0] == {1'b0, $past(hdr_chan_b), $past(hdr_chan_a),
                             1'b0, $past(hdr_preamble), $past(hdr_sync), $past(hdr_startup)}
                             && s_ff.typ[7:4] == TYPE_PROT_FLEXRAY)
        else $error("flexray flags wrong");
    a_flexray_cycle:
        assert property (accept && hdr_prot == PROT_FLEXRAY
                         && len_ok(hdr_prot, hdr_valid_byte_count)
                         |=> s_ff.info == {2'b00, $past(hdr_cycle)})
        else $error("cycle count not in info");
    a_lin_fields:
        assert property (accept && hdr_prot == PROT_LIN
                         && len_ok(hdr_prot, hdr_valid_byte_count)
                         |=> s_ff.flags[6:1] == 6'h00
                             && s_ff.info == ($past(hdr_event_slot) ?
                                              {2'b00, $past(hdr_event_id)} : 8'h00))
        else $error("lin info or flags wrong");
    a_can_unused:
        assert property (accept && (hdr_prot == PROT_CAN || hdr_prot == PROT_CANFD)
                         && len_ok(hdr_prot, hdr_valid_byte_count)
                         |=> s_ff.flags[6:0] == 7'h00 && s_ff.info == 8'h00)
        else $error("can flags or info not zero");
    a_short_single:
        assert property (rec_valid && rec_ready && s_ff.kind == KIND_BASE
                         && s_ff.len <= CLASSIC_MAX_LEN |-> rec_last)
        else $error("short frame has extra units");
    a_record_size:
        assert property (rec_valid && rec_ready && rec_last
                         |-> {s_ff.words, 3'b000} == rec_size(s_ff.len))
        else $error("record size mismatch");
    a_back_to_back:
        assert property (rec_valid && rec_ready && rec_last && accept
                         && len_ok(hdr_prot, hdr_valid_byte_count)
                         |=> rec_valid && s_ff.kind == KIND_TS ##1 s_ff.st == ST_HDR
                             || s_ff.kind == KIND_HDR)
        else $error("gap between records");
    a_refused_len:
        assert property (accept && !len_ok(hdr_prot, hdr_valid_byte_count) |=> !rec_valid)
        else $error("illegal length was emitted");
    a_flexray_max:
        assert property (accept && hdr_prot == PROT_FLEXRAY
                         && hdr_valid_byte_count == FLEXRAY_MAX_LEN
                         |=> s_ff.ext_left == MAX_EXT_UNITS)
        else $error("longest flexray frame unit count wrong");
    a_pad_zero:
        assert property (rec_valid && s_ff.kind == KIND_BASE && s_ff.ctrl[CTRL_PAD_ZERO]
                         && s_ff.len < CLASSIC_MAX_LEN
                         |-> (rec_data >> {s_ff.len, 3'b000}) == 64'h0)
        else $error("padding bytes not zero");

    c_fd_64: cover property (rec_valid && rec_ready && rec_last && s_ff.len == 8'h40);
    c_fr_max: cover property (rec_valid && rec_ready && rec_last
                              && s_ff.last_size == MAX_RECORD_BYTES);
    c_lin_slot: cover property (accept && hdr_prot == PROT_LIN && hdr_event_slot);
    c_b2b: cover property (rec_valid && rec_ready && rec_last && accept);

endmodule : raw_frame_record_packer

`default_nettype wire

//--- tb/rec_sink.sv
`default_nettype none

module rec_sink (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        rec_valid,
    input  wire logic [63:0] rec_data,
    input  wire logic        rec_last,
    output logic             rec_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [63:0] words[$];
    logic        lasts[$];
    logic [1:0]  cnt = 2'h0;
    // ==========================================
    // Host reader, stalls one cycle in four
    always @(posedge pclk) begin
        cnt <= cnt + 2'h1;
        rec_ready <= (cnt != 2'h2);
        if (presetn && rec_valid && rec_ready) begin
            words.push_back(rec_data);
            lasts.push_back(rec_last);
        end
    end
endmodule : rec_sink

`default_nettype wire

//--- tb/tb_raw_frame_record_packer.sv
`default_nettype none

module tb_raw_frame_record_packer;
    timeunit 1ns;
    timeprecision 1ps;
    import record_pack_pkg::*;
    localparam logic [63:0] TS   = 64'h0123456789abcdef;
    localparam logic [63:0] BASE = 64'h8877665544332211;
    localparam logic [63:0] EXT  = 64'hf0e0d0c0b0a09080;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        hdr_valid = 1'b0;
    logic        hdr_ready;
    prot_e       hdr_prot = PROT_CAN;
    logic [7:0]  fl = 8'h00;
    logic [28:0] hdr_id = 29'h0;
    logic [7:0]  vbc = 8'h00;
    logic        pl_valid = 1'b0;
    logic        pl_ready;
    logic [63:0] pl_data = 64'h0;
    logic        rec_valid;
    logic        rec_ready;
    logic [63:0] rec_data;
    logic        rec_last;
    logic [31:0] q;
    logic        e;
    logic        pad = 1'b1;
    logic        b2b = 1'b0;
    int          num_errors = 0;
    int          checked = 0;
    int          cycles = 0;

    raw_frame_record_packer uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hdr_valid(hdr_valid), .hdr_ready(hdr_ready),
        .hdr_prot(hdr_prot), .hdr_subtype(4'h5), .hdr_timestamp(TS), .hdr_id(hdr_id),
        .hdr_extended(fl[3]), .hdr_echo(fl[7]), .hdr_startup(fl[0]), .hdr_sync(fl[1]),
        .hdr_preamble(fl[2]), .hdr_chan_a(fl[4]), .hdr_chan_b(fl[5]), .hdr_event_slot(fl[0]),
        .hdr_event_id(~hdr_id[5:0]), .hdr_cycle(hdr_id[5:0]), .hdr_valid_byte_count(vbc),
        .hdr_payload(BASE), .pl_valid(pl_valid), .pl_ready(pl_ready), .pl_data(pl_data),
        .rec_valid(rec_valid), .rec_ready(rec_ready), .rec_data(rec_data), .rec_last(rec_last));
    rec_sink sink (.pclk(pclk), .presetn(presetn), .rec_valid(rec_valid),
        .rec_data(rec_data), .rec_last(rec_last), .rec_ready(rec_ready));

    // ==========================================
    // Helpers
    always #2.5 pclk = ~pclk;
    function automatic logic [63:0] msk(input logic [63:0] v, input int nb);
        for (int b = nb; b < 8; b++) if (pad) v[8*b +: 8] = 8'h00;
        return v;
    endfunction : msk
    task automatic chk(input logic [63:0] g, input logic [63:0] x, input string s);
        checked++;
        if (g !== x) begin
            num_errors++;
            $display("[ERR] %0t %s", $time, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic frame(input prot_e p, input logic [7:0] f, input logic [7:0] len,
                         input logic [28:0] id, input int nx);
        hdr_valid <= 1'b1;
        hdr_prot <= p;
        fl <= f;
        vbc <= len;
        hdr_id <= id;
        do @(posedge pclk); while (hdr_ready !== 1'b1);
        if (!b2b) begin
            hdr_valid <= 1'b0;
        end
        for (int i = 0; i < nx; i++) begin
            pl_valid <= 1'b1;
            pl_data <= EXT ^ 64'(i);
            do @(posedge pclk); while (pl_ready !== 1'b1);
        end
        pl_valid <= 1'b0;
    endtask : frame
    task automatic rec(input logic [7:0] ty, fx, inf, len, input logic [31:0] id);
        int n;
        n = 3 + ((len > 8) ? ((len - 1) >> 3) : 0);
        while (sink.words.size() < n) @(posedge pclk);
        chk(sink.words[0], TS, "timestamp word");
        chk(sink.words[1], {len, inf, fx, ty, id}, "header word");
        chk(sink.words[2], msk(BASE, len), "base payload");
        for (int i = 3; i < n; i++) chk(sink.words[i], msk(EXT ^ 64'(i - 3), len - 8 * (i - 2)),
            "ext payload");
        for (int i = 0; i < n; i++) chk(64'(sink.lasts[i]), 64'(i == n - 1), "last flag");
        repeat (n) begin
            void'(sink.words.pop_front());
            void'(sink.lasts.pop_front());
        end
        $display("record of %0d words done", n);
    endtask : rec
    task automatic conclude;
        $display("checks %0d, errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude

    // ==========================================
    // Tests
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        frame(PROT_CAN, 8'h88, 8'h08, 29'h1bcdef01, 0);
        rec(8'h05, 8'h80, 8'h00, 8'h08, 32'h3bcdef01);
        frame(PROT_FLEXRAY, 8'hb7, 8'h0c, 29'h3f, 1);
        rec(8'h25, 8'hb7, 8'h3f, 8'h0c, 32'h3f);
        frame(PROT_CANFD, 8'h00, 8'h0d, 29'h7ff, 1);
        b2b = 1'b1;
        frame(PROT_LIN, 8'h01, 8'h03, 29'h05, 0);
        b2b = 1'b0;
        frame(PROT_LIN, 8'h00, 8'h00, 29'h05, 0);
        rec(8'h45, 8'h01, 8'h3a, 8'h03, 32'h11);
        rec(8'h45, 8'h00, 8'h00, 8'h00, 32'h05);
        frame(PROT_CANFD, 8'h00, 8'h40, 29'h7ff, 7);
        rec(8'h05, 8'h00, 8'h00, 8'h40, 32'h7ff);
        apb(1'b0, REG_LAST_SIZE, 32'h0);
        chk({32'h0, q}, 64'd80, "record size");
        apb(1'b0, REG_DROP_CNT, 32'h0);
        chk({32'h0, q}, 64'd1, "drop count");
        apb(1'b0, 12'h040, 32'h0);
        chk({63'h0, e}, 64'd1, "unmapped error");
        apb(1'b1, REG_CTRL, 32'h0);
        @(posedge pclk);
        chk({63'h0, hdr_ready}, 64'd0, "disabled block accepts");
        apb(1'b1, REG_CTRL, 32'h1);
        apb(1'b0, REG_CTRL, 32'h0);
        chk({32'h0, q}, 64'd1, "control readback");
        pad = 1'b0;
        frame(PROT_CAN, 8'h80, 8'h02, 29'h123, 0);
        rec(8'h05, 8'h80, 8'h00, 8'h02, 32'h123);
        frame(PROT_FLEXRAY, 8'h40, 8'hfe, 29'h2a5, 31);
        rec(8'h25, 8'h00, 8'h25, 8'hfe, 32'h2a5);
        apb(1'b0, REG_LAST_SIZE, 32'h0);
        chk({32'h0, q}, 64'd272, "longest record size");
        apb(1'b0, REG_REC_CNT, 32'h0);
        chk({32'h0, q}, 64'd7, "record count");
        conclude();
    end
endmodule : tb_raw_frame_record_packer

`default_nettype wire
